// *** design/scdf_regs.svh ***
// register offsets, field positions, reset values and counts of the serial config block
//
// Behaviour
// - Fast detect flag holds until magnitude stays below lower threshold for dwell time.
// - Lower threshold is 16 bits over two registers, compared with input sample magnitude before dc correction.
// - Threshold code two to the thirteenth equals full-scale magnitude.
// - Dwell is 1 to 65535 sample cycles, held in two host-written registers.
// - DC correction is high-pass; bandwidth select sits in control bits 5 to 2.
// - Bandwidth is fs times 2^(-k-14) over 2pi; k valid 0 through 13.
// - Present 16-bit dc correction value is readable across two registers.
// - Freeze bit stops estimate updates; last value stays applied until cleared.
// - Enable bit applies dc correction to output data; otherwise data uncorrected.
// - Host drives clock and select; data line input on writes, output on reads.
// - Frame starts at first serial clock rise after select goes low.
// - Select held low with length bits 11 streams; device keeps accepting or returning bytes.
// - Select may rise between bytes of a counted frame to stall without losing frame state; a streaming frame restarts.
// - Select high puts serial pins in high impedance and enables secondary functions.
// - Frame opens with 16-bit instruction; two length bits; data words are bytes.
// - Leading instruction bit selects read; on read device drives data line.
// - Bit order is MSB first after reset; port config can select LSB first.
// - Flag sets when magnitude exceeds 16-bit upper threshold; latency four cycles.
// - Fast detect enabled by control bit 0; flag low below threshold; sign ignored.
// - Correction and detect writes are shadowed; writing 0x01 to transfer applies them.
`ifndef SCDF_REGS_SVH
`define SCDF_REGS_SVH

`define SCDF_ADDR_PORT_CFG 13'h0000
`define SCDF_ADDR_DCC_CTRL 13'h0040
`define SCDF_ADDR_DCC_VAL_LO 13'h0041
`define SCDF_ADDR_DCC_VAL_HI 13'h0042
`define SCDF_ADDR_FD_CTRL 13'h0045
`define SCDF_ADDR_FD_UP_LO 13'h0047
`define SCDF_ADDR_FD_UP_HI 13'h0048
`define SCDF_ADDR_FD_LO_LO 13'h0049
`define SCDF_ADDR_FD_LO_HI 13'h004A
`define SCDF_ADDR_DWELL_LO 13'h004B
`define SCDF_ADDR_DWELL_HI 13'h004C
`define SCDF_ADDR_XFER 13'h00FF

`define SCDF_PORT_LSB_A 6
`define SCDF_PORT_LSB_B 1
`define SCDF_DCC_FREEZE_BIT 6
`define SCDF_DCC_K_HI 5
`define SCDF_DCC_K_LO 2
`define SCDF_DCC_EN_BIT 1
`define SCDF_FD_EN_BIT 0
`define SCDF_XFER_BIT 0

`define SCDF_PORT_CFG_RST 8'h18
`define SCDF_CFG_RST 55'h0
`define SCDF_DCC_K_MAX 4'hD
`define SCDF_DCC_SHIFT_BASE 6'h0E
`define SCDF_INSTR_LAST 4'hF
`define SCDF_BYTE_LAST 4'h7
`define SCDF_LEN_STREAM 2'h3
`define SCDF_FD_LATENCY 4

`endif

// *** design/scdf_pkg.sv ***
// types shared by the serial config, dc correction and fast detect block
package scdf_pkg;

   typedef enum logic [3:0] {
      PH_IDLE = 4'h1,
      PH_INSTR = 4'h2,
      PH_WDATA = 4'h4,
      PH_RDATA = 4'h8
   } scdf_phase_t;

   typedef struct packed {
      logic fdEn;
      logic dccFreeze;
      logic dccEn;
      logic [3:0] dccK;
      logic [15:0] upper;
      logic [15:0] lower;
      logic [15:0] dwell;
   } scdf_cfg_t;

   typedef struct packed {
      logic sclkMeta;
      logic sclkSync;
      logic sclkLast;
      logic csMeta;
      logic csSync;
      logic sdiMeta;
      logic sdiSync;
      scdf_phase_t phase;
      logic [3:0] bitCnt;
      logic [15:0] shiftIn;
      logic [1:0] lenCode;
      logic [1:0] bytesLeft;
      logic [12:0] addr;
      logic [7:0] txByte;
      logic sdioOut;
      logic sdioOe;
      logic secondaryEn;
      logic lsbFirst;
      scdf_cfg_t shadow;
      scdf_cfg_t active;
      logic signed [47:0] dcAcc;
      logic signed [15:0] x1;
      logic [15:0] mag;
      logic overUp;
      logic underLo;
      logic fdFlag;
      logic [15:0] dwellCnt;
      logic [15:0] dataOut;
   } scdf_state_t;

endpackage

// *** design/scdf_top.sv ***
// serial config port with shadowed dc correction and fast threshold detect
`timescale 1ns/1ps
`include "scdf_regs.svh"

module scdf_top
   import scdf_pkg::*;
#(
   parameter int SAMPLE_W = 14
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic csN,
   input wire logic sdioIn,
   output logic sdioOut,
   output logic sdioOe,
   output logic secondaryEn,
   input wire logic [SAMPLE_W-1:0] adcIn,
   output logic [SAMPLE_W-1:0] dataOut,
   output logic fastDetect
);

   // ************************************************************
   // constants and helpers
   // ************************************************************
   localparam logic signed [16:0] SMAX = 17'((1 <<< (SAMPLE_W - 1)) - 1);
   localparam logic signed [16:0] SMIN = 17'(-(1 <<< (SAMPLE_W - 1)));

   function automatic scdf_state_t stRst();
      scdf_state_t s;
      s = '0;
      s.phase = PH_IDLE;
      s.csMeta = 1'b1;
      s.csSync = 1'b1;
      // idle-high serial clock shows no false rise after reset
      s.sclkMeta = 1'b1;
      s.sclkSync = 1'b1;
      s.sclkLast = 1'b1;
      s.shadow = `SCDF_CFG_RST;
      s.active = `SCDF_CFG_RST;
      return s;
   endfunction

   localparam scdf_state_t ST_RST = stRst();

   function automatic logic [7:0] rev8(input logic [7:0] b);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++) begin
         r[i] = b[7-i];
      end
      return r;
   endfunction

   function automatic logic [7:0] regRd(input logic [12:0] a, input scdf_state_t s);
      logic [7:0] d;
      d = 8'h00;
      if (a == `SCDF_ADDR_PORT_CFG) begin
         d = `SCDF_PORT_CFG_RST | {1'b0, s.lsbFirst, 4'h0, s.lsbFirst, 1'b0};
      end else if (a == `SCDF_ADDR_DCC_CTRL) begin
         d = {1'b0, s.shadow.dccFreeze, s.shadow.dccK, s.shadow.dccEn, 1'b0};
      end else if (a == `SCDF_ADDR_DCC_VAL_LO) begin
         d = s.dcAcc[39:32];
      end else if (a == `SCDF_ADDR_DCC_VAL_HI) begin
         d = s.dcAcc[47:40];
      end else if (a == `SCDF_ADDR_FD_CTRL) begin
         d = {7'h00, s.shadow.fdEn};
      end else if (a == `SCDF_ADDR_FD_UP_LO) begin
         d = s.shadow.upper[7:0];
      end else if (a == `SCDF_ADDR_FD_UP_HI) begin
         d = s.shadow.upper[15:8];
      end else if (a == `SCDF_ADDR_FD_LO_LO) begin
         d = s.shadow.lower[7:0];
      end else if (a == `SCDF_ADDR_FD_LO_HI) begin
         d = s.shadow.lower[15:8];
      end else if (a == `SCDF_ADDR_DWELL_LO) begin
         d = s.shadow.dwell[7:0];
      end else if (a == `SCDF_ADDR_DWELL_HI) begin
         d = s.shadow.dwell[15:8];
      end
      return d;
   endfunction

   scdf_state_t st_r;
   scdf_state_t st_nxt;
   logic rise;
   logic fall;
   logic csLow;
   logic xferHit;
   logic [15:0] shifted;
   logic [15:0] word;
   logic [7:0] byteIn;
   logic [12:0] addrStep;
   logic [3:0] kEff;
   logic [5:0] shamt;
   logic signed [47:0] err;
   logic signed [15:0] dc;
   logic signed [16:0] diff;
   logic signed [16:0] ext;
   logic [16:0] absv;
   logic [16:0] dwellNext;
   logic [15:0] dwellEff;
   logic lastByte;

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      st_nxt = st_r;
      // pins cross into core_clk through two flops before use
      st_nxt.sclkMeta = sclk;
      st_nxt.sclkSync = st_r.sclkMeta;
      st_nxt.sclkLast = st_r.sclkSync;
      st_nxt.csMeta = csN;
      st_nxt.csSync = st_r.csMeta;
      st_nxt.sdiMeta = sdioIn;
      st_nxt.sdiSync = st_r.sdiMeta;
      rise = st_r.sclkSync & ~st_r.sclkLast;
      fall = ~st_r.sclkSync & st_r.sclkLast;
      csLow = ~st_r.csSync;
      shifted = {st_r.shiftIn[14:0], st_r.sdiSync};
      word = st_r.lsbFirst ? {rev8(shifted[7:0]), rev8(shifted[15:8])} : shifted;
      byteIn = st_r.lsbFirst ? rev8(shifted[7:0]) : shifted[7:0];
      // address walks down in msb-first mode, up in lsb-first mode
      addrStep = st_r.lsbFirst ? st_r.addr + 13'h0001 : st_r.addr - 13'h0001;
      lastByte = (st_r.lenCode != `SCDF_LEN_STREAM) && (st_r.bytesLeft == 2'h0);
      xferHit = 1'b0;
      st_nxt.secondaryEn = st_r.csSync;

      // ************************************************************
      // serial frame engine
      // ************************************************************
      if (!csLow) begin
         st_nxt.sdioOe = 1'b0;
         // a counted frame paused on a byte boundary keeps its place
         if (!((st_r.phase == PH_WDATA || st_r.phase == PH_RDATA) &&
               st_r.bitCnt == 4'h0 && st_r.lenCode != `SCDF_LEN_STREAM)) begin
            st_nxt.phase = PH_IDLE;
            st_nxt.bitCnt = 4'h0;
         end
      end else if (rise) begin
         case (st_r.phase)
            PH_IDLE: begin
               st_nxt.shiftIn = shifted;
               st_nxt.bitCnt = 4'h1;
               st_nxt.phase = PH_INSTR;
            end
            PH_INSTR: begin
               st_nxt.shiftIn = shifted;
               st_nxt.bitCnt = st_r.bitCnt + 4'h1;
               if (st_r.bitCnt == `SCDF_INSTR_LAST) begin
                  st_nxt.bitCnt = 4'h0;
                  st_nxt.lenCode = word[14:13];
                  st_nxt.bytesLeft = word[14:13];
                  st_nxt.addr = word[12:0];
                  st_nxt.phase = word[15] ? PH_RDATA : PH_WDATA;
                  st_nxt.txByte = regRd(word[12:0], st_r);
               end
            end
            PH_WDATA: begin
               st_nxt.shiftIn = shifted;
               st_nxt.bitCnt = st_r.bitCnt + 4'h1;
               if (st_r.bitCnt == `SCDF_BYTE_LAST) begin
                  st_nxt.bitCnt = 4'h0;
                  st_nxt.addr = addrStep;
                  if (st_r.addr == `SCDF_ADDR_PORT_CFG) begin
                     st_nxt.lsbFirst = byteIn[`SCDF_PORT_LSB_A] | byteIn[`SCDF_PORT_LSB_B];
                  end else if (st_r.addr == `SCDF_ADDR_DCC_CTRL) begin
                     st_nxt.shadow.dccFreeze = byteIn[`SCDF_DCC_FREEZE_BIT];
                     st_nxt.shadow.dccK = byteIn[`SCDF_DCC_K_HI:`SCDF_DCC_K_LO];
                     st_nxt.shadow.dccEn = byteIn[`SCDF_DCC_EN_BIT];
                  end else if (st_r.addr == `SCDF_ADDR_FD_CTRL) begin
                     st_nxt.shadow.fdEn = byteIn[`SCDF_FD_EN_BIT];
                  end else if (st_r.addr == `SCDF_ADDR_FD_UP_LO) begin
                     st_nxt.shadow.upper[7:0] = byteIn;
                  end else if (st_r.addr == `SCDF_ADDR_FD_UP_HI) begin
                     st_nxt.shadow.upper[15:8] = byteIn;
                  end else if (st_r.addr == `SCDF_ADDR_FD_LO_LO) begin
                     st_nxt.shadow.lower[7:0] = byteIn;
                  end else if (st_r.addr == `SCDF_ADDR_FD_LO_HI) begin
                     st_nxt.shadow.lower[15:8] = byteIn;
                  end else if (st_r.addr == `SCDF_ADDR_DWELL_LO) begin
                     st_nxt.shadow.dwell[7:0] = byteIn;
                  end else if (st_r.addr == `SCDF_ADDR_DWELL_HI) begin
                     st_nxt.shadow.dwell[15:8] = byteIn;
                  end else if (st_r.addr == `SCDF_ADDR_XFER) begin
                     xferHit = byteIn[`SCDF_XFER_BIT];
                  end
                  if (lastByte) begin
                     st_nxt.phase = PH_IDLE;
                  end else if (st_r.lenCode != `SCDF_LEN_STREAM) begin
                     st_nxt.bytesLeft = st_r.bytesLeft - 2'h1;
                  end
               end
            end
            PH_RDATA: begin
               st_nxt.bitCnt = st_r.bitCnt + 4'h1;
               if (st_r.bitCnt == `SCDF_BYTE_LAST) begin
                  st_nxt.bitCnt = 4'h0;
                  st_nxt.addr = addrStep;
                  st_nxt.txByte = regRd(addrStep, st_r);
                  if (lastByte) begin
                     st_nxt.phase = PH_IDLE;
                     st_nxt.sdioOe = 1'b0;
                  end else if (st_r.lenCode != `SCDF_LEN_STREAM) begin
                     st_nxt.bytesLeft = st_r.bytesLeft - 2'h1;
                  end
               end
            end
            default: begin
               st_nxt.phase = PH_IDLE;
            end
         endcase
      end else if (fall && st_r.phase == PH_RDATA) begin
         // read data launches on the falling edge, host samples on the rise
         st_nxt.sdioOe = 1'b1;
         st_nxt.sdioOut = st_r.lsbFirst ? st_r.txByte[0] : st_r.txByte[7];
         st_nxt.txByte = st_r.lsbFirst ? {1'b0, st_r.txByte[7:1]} : {st_r.txByte[6:0], 1'b0};
      end
      // all shadowed fields land in the same cycle
      if (xferHit) begin
         st_nxt.active = st_nxt.shadow;
      end

      // ************************************************************
      // dc correction
      // ************************************************************
      st_nxt.x1 = 16'($signed(adcIn));
      kEff = (st_r.active.dccK > `SCDF_DCC_K_MAX) ? `SCDF_DCC_K_MAX : st_r.active.dccK;
      shamt = {2'h0, kEff} + `SCDF_DCC_SHIFT_BASE;
      err = {st_r.x1, 32'h0} - st_r.dcAcc;
      if (!st_r.active.dccFreeze) begin
         st_nxt.dcAcc = st_r.dcAcc + (err >>> shamt);
      end
      dc = st_r.dcAcc[47:32];
      diff = {st_r.x1[15], st_r.x1} - {dc[15], dc};
      if (!st_r.active.dccEn) begin
         st_nxt.dataOut = st_r.x1;
      end else if (diff > SMAX) begin
         st_nxt.dataOut = SMAX[15:0];
      end else if (diff < SMIN) begin
         st_nxt.dataOut = SMIN[15:0];
      end else begin
         st_nxt.dataOut = diff[15:0];
      end

      // ************************************************************
      // fast detect, four stages from input to flag
      // ************************************************************
      ext = {st_r.x1[15], st_r.x1};
      absv = ext[16] ? 17'(-ext) : 17'(ext);
      st_nxt.mag = absv[15:0];
      // code 2^13 is full scale, so thresholds compare directly
      st_nxt.overUp = st_r.mag > st_r.active.upper;
      st_nxt.underLo = st_r.mag < st_r.active.lower;
      dwellNext = {1'b0, st_r.dwellCnt} + 17'h00001;
      dwellEff = (st_r.active.dwell == 16'h0000) ? 16'h0001 : st_r.active.dwell;
      if (!st_r.active.fdEn) begin
         st_nxt.fdFlag = 1'b0;
         st_nxt.dwellCnt = 16'h0000;
      end else if (st_r.overUp) begin
         st_nxt.fdFlag = 1'b1;
         st_nxt.dwellCnt = 16'h0000;
      end else if (st_r.fdFlag && st_r.underLo) begin
         // a run of samples below the lower threshold clears the flag
         if (dwellNext >= {1'b0, dwellEff}) begin
            st_nxt.fdFlag = 1'b0;
            st_nxt.dwellCnt = 16'h0000;
         end else begin
            st_nxt.dwellCnt = dwellNext[15:0];
         end
      end else begin
         st_nxt.dwellCnt = 16'h0000;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sdioOut = st_r.sdioOut;
   assign sdioOe = st_r.sdioOe;
   assign secondaryEn = st_r.secondaryEn;
   assign dataOut = st_r.dataOut[SAMPLE_W-1:0];
   assign fastDetect = st_r.fdFlag;

   // ************************************************************
   // assertions
   // ************************************************************
   logic [16:0] inExt;
   logic [16:0] inMag;
   assign inExt = 17'($signed(adcIn));
   assign inMag = inExt[16] ? 17'(-inExt) : inExt;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   sequence sBigIn;
      st_r.active.fdEn && (inMag > {1'b0, st_r.active.upper});
   endsequence
   sequence sCfgSteady;
      (st_r.active.fdEn && $stable(st_r.active))[*3];
   endsequence
   sequence sInstrDone;
      csLow && rise && st_r.phase == PH_INSTR && st_r.bitCnt == `SCDF_INSTR_LAST;
   endsequence

   AST_FD_LATENCY: assert property (sBigIn ##1 sCfgSteady |=> fastDetect)
      else $error("flag missing four cycles after large sample");
   AST_FD_HOLD: assert property (fastDetect && st_r.active.fdEn && !st_r.underLo
      |=> fastDetect)
      else $error("flag cleared without a sample below the lower threshold");
   AST_FD_OFF: assert property (!st_r.active.fdEn |=> !fastDetect)
      else $error("flag set while detect disabled");
   AST_FD_DWELL: assert property ($fell(fastDetect) && $past(st_r.active.fdEn)
      |-> ({1'b0, $past(st_r.dwellCnt)} + 17'h00001 >= {1'b0, $past(st_r.active.dwell)}))
      else $error("flag cleared before dwell elapsed");
   AST_DCC_FREEZE: assert property (st_r.active.dccFreeze |=> $stable(st_r.dcAcc))
      else $error("dc estimate moved while frozen");
   AST_DCC_BYPASS: assert property (!st_r.active.dccEn |=> st_r.dataOut == $past(st_r.x1))
      else $error("data altered with correction disabled");
   AST_XFER: assert property (xferHit |=> st_r.active == st_r.shadow)
      else $error("transfer did not apply shadow settings");
   AST_OE_READ: assert property (sdioOe |-> st_r.phase == PH_RDATA && !$past(st_r.csSync))
      else $error("data line driven outside read data phase");
   AST_OE_SEC: assert property (sdioOe |-> !secondaryEn)
      else $error("secondary function enabled while data line driven");
   AST_FD_SET: assert property (st_r.active.fdEn && st_r.overUp |=> fastDetect)
      else $error("flag not set after magnitude over upper threshold");
   AST_CS_HIZ: assert property (st_r.csSync |=> !sdioOe && secondaryEn)
      else $error("pins not released with select high");
   AST_INSTR: assert property (sInstrDone |=> st_r.phase inside {PH_WDATA, PH_RDATA})
      else $error("no data phase after sixteen instruction bits");

endmodule

// *** dv/scdf_host.sv ***
// host-side serial master model for the three-wire configuration port
`timescale 1ns/1ps

module scdf_host (
   input wire logic core_clk,
   input wire logic sdioOut,
   input wire logic sdioOe,
   output logic sclk,
   output logic csN,
   output logic sdioLine
);
   // ************************************************
   // line resolution and bit timing
   // ************************************************
   logic hostOe;
   logic hostBit;
   logic lastLine;
   logic lsbFirst;

   // released line shows the inverse of its last level, never a stale copy
   assign sdioLine = sdioOe ? sdioOut : (hostOe ? hostBit : ~lastLine);

   always @(posedge core_clk) begin
      lastLine <= sdioLine;
   end

   initial begin
      sclk = 1'b1;
      csN = 1'b1;
      hostOe = 1'b0;
      hostBit = 1'b0;
      lastLine = 1'b0;
      lsbFirst = 1'b0;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // one serial period: fall, drive, sample the line, rise
   task automatic bitx(input logic drv, input logic b, output logic got);
      sclk <= 1'b0;
      hostOe <= drv;
      hostBit <= b;
      cyc(8);
      got = sdioLine;
      sclk <= 1'b1;
      cyc(8);
   endtask

   // stall only at byte boundaries of counted frames
   task automatic xfer(input logic rd, input logic [1:0] len, input logic [12:0] addr,
         input int n, input logic stall, inout logic [7:0] d [8]);
      logic [15:0] ins;
      logic g;
      int i;
      int j;
      ins = {rd, len, addr};
      cyc(1);
      csN <= 1'b0;
      cyc(8);
      for (i = 0; i < 16; i++) begin
         bitx(1'b1, lsbFirst ? ins[i] : ins[15-i], g);
      end
      for (j = 0; j < n; j++) begin
         if (stall && j > 0) begin
            csN <= 1'b1;
            cyc(24);
            csN <= 1'b0;
            cyc(8);
         end
         for (i = 0; i < 8; i++) begin
            bitx(!rd, lsbFirst ? d[j][i] : d[j][7-i], g);
            if (rd) begin
               d[j][lsbFirst ? i : 7 - i] = g;
            end
         end
      end
      hostOe <= 1'b0;
      csN <= 1'b1;
      cyc(8);
   endtask
endmodule

// *** dv/scdf_top_tb.sv ***
// self-checking bench for the serial config, dc correction and fast detect block
`timescale 1ns/1ps
`include "scdf_regs.svh"

module scdf_top_tb;
   // ************************************************
   // clock, reset, wiring
   // ************************************************
   logic core_clk;
   logic rst_n;
   logic sclk;
   logic csN;
   logic sdioLine;
   logic sdioOut;
   logic sdioOe;
   logic secondaryEn;
   logic [13:0] adcIn;
   logic [13:0] dataOut;
   logic fastDetect;
   int failures;
   int samples_checked;
   int i;
   int t;
   int dw;
   logic [7:0] d [8];
   logic [7:0] e [8];
   logic [15:0] up;
   logic [15:0] v;
   logic [13:0] c;
   logic [1:0] x;

   scdf_top #(.SAMPLE_W(14)) dut (.core_clk(core_clk), .rst_n(rst_n), .sclk(sclk),
      .csN(csN), .sdioIn(sdioLine), .sdioOut(sdioOut), .sdioOe(sdioOe),
      .secondaryEn(secondaryEn), .adcIn(adcIn), .dataOut(dataOut), .fastDetect(fastDetect));

   scdf_host host (.core_clk(core_clk), .sdioOut(sdioOut), .sdioOe(sdioOe), .sclk(sclk),
      .csN(csN), .sdioLine(sdioLine));

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // ************************************************
   // compare, access and closing tasks
   // ************************************************
   task automatic miss(input logic [15:0] got, input logic [15:0] exp);
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
   endtask
   task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) miss(got, exp);
   endtask
   task automatic chkBit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) miss(got, exp);
   endtask
   task automatic chkSample(input logic [13:0] got, input logic [13:0] exp);
      samples_checked++;
      if (got !== exp) miss(got, exp);
   endtask
   task automatic wr(input logic [12:0] a, input logic [7:0] val);
      d[0] = val;
      host.xfer(1'b0, 2'h0, a, 1, 1'b0, d);
   endtask
   task automatic rdc(input logic [12:0] a, input logic [7:0] exp);
      d[0] = 8'h00;
      host.xfer(1'b1, 2'h0, a, 1, 1'b0, d);
      chkByte(d[0], exp);
   endtask
   task automatic test_done;
      $display("checked=%0d failures=%0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // {check now, expected flag}; a mid-band sample restarts the dwell count
   function automatic logic [1:0] fdExp(input int tt, input int dwl);
      if (tt == 3 || tt == 2 * dwl + 4 || tt == 2 * dwl + 9) return 2'h2;
      if (tt == 4 || tt == 5 || tt == 2 * dwl + 3) return 2'h3;
      return 2'h0;
   endfunction

   initial begin
      repeat (100000) @(posedge core_clk);
      failures++;
      test_done;
   end

   // ************************************************
   // main sequence
   // ************************************************
   initial begin
      rst_n = 1'b0;
      adcIn = 14'h0000;
      failures = 0;
      samples_checked = 0;
      void'($urandom(32'h098C13D3));
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge core_clk);
      chkBit(secondaryEn, 1'b1);
      chkBit(sdioOe, 1'b0);
      rdc(`SCDF_ADDR_PORT_CFG, `SCDF_PORT_CFG_RST);
      rdc(`SCDF_ADDR_DCC_CTRL, 8'h00);
      $display("test reset done");

      for (i = 0; i < 4; i++) e[i] = 8'($urandom);
      d = e;
      host.xfer(1'b0, `SCDF_LEN_STREAM, `SCDF_ADDR_DWELL_HI, 4, 1'b0, d);
      host.xfer(1'b1, 2'h2, `SCDF_ADDR_DWELL_HI, 3, 1'b1, d);
      for (i = 0; i < 3; i++) chkByte(d[i], e[i]);
      rdc(13'h0013, 8'h00);
      wr(`SCDF_ADDR_DCC_VAL_LO, 8'hA5);
      rdc(`SCDF_ADDR_DCC_VAL_LO, 8'h00);
      wr(`SCDF_ADDR_XFER, 8'h01);
      rdc(`SCDF_ADDR_XFER, 8'h00);
      $display("test register access done");

      wr(`SCDF_ADDR_PORT_CFG, 8'h5A);
      host.lsbFirst = 1'b1;
      fork
         host.xfer(1'b1, 2'h1, `SCDF_ADDR_FD_LO_LO, 2, 1'b0, d);
         begin
            repeat (40) @(posedge core_clk);
            @(negedge core_clk);
            chkBit(secondaryEn, 1'b0);
         end
      join
      chkByte(d[0], e[3]);
      chkByte(d[1], e[2]);
      wr(`SCDF_ADDR_PORT_CFG, 8'h18);
      host.lsbFirst = 1'b0;
      rdc(`SCDF_ADDR_PORT_CFG, 8'h18);
      $display("test bit order done");

      for (i = 0; i < 14; i++) begin
         wr(`SCDF_ADDR_DCC_CTRL, {2'b00, 4'(i), 2'b00});
         rdc(`SCDF_ADDR_DCC_CTRL, {2'b00, 4'(i), 2'b00});
      end
      $display("test bandwidth select done");

      up = 16'($urandom_range(16'h1000, 16'h0400));
      dw = $urandom_range(8, 6);
      d = '{8'h00, 8'(dw), 8'(up >> 9), 8'(up >> 1), up[15:8], up[7:0], 8'h00, 8'h00};
      host.xfer(1'b0, `SCDF_LEN_STREAM, `SCDF_ADDR_DWELL_HI, 6, 1'b0, d);
      wr(`SCDF_ADDR_FD_CTRL, 8'h01);
      adcIn <= 14'(-(int'(up) + 1));
      repeat (10) @(posedge core_clk);
      chkBit(fastDetect, 1'b0);
      adcIn <= 14'h0000;
      wr(`SCDF_ADDR_XFER, 8'h01);
      for (t = 0; t <= 2 * dw + 9; t++) begin
         @(posedge core_clk);
         adcIn <= (t == 0) ? 14'(-(int'(up) + 1)) : (t == dw) ? 14'((up >> 1) + 1) : 14'h0000;
         @(negedge core_clk);
         x = fdExp(t, dw);
         if (x[1]) chkBit(fastDetect, x[0]);
      end
      $display("test fast detect done");

      c = 14'($urandom_range(2047, 512));
      adcIn <= c;
      repeat (6) @(posedge core_clk);
      chkSample(dataOut, c);
      wr(`SCDF_ADDR_DCC_CTRL, 8'h02);
      wr(`SCDF_ADDR_XFER, 8'h01);
      repeat (3000) @(posedge core_clk);
      wr(`SCDF_ADDR_DCC_CTRL, 8'h42);
      wr(`SCDF_ADDR_XFER, 8'h01);
      host.xfer(1'b1, 2'h1, `SCDF_ADDR_DCC_VAL_HI, 2, 1'b0, d);
      v = {d[0], d[1]};
      chkBit(v != 16'h0000 && v < 16'(c), 1'b1);
      @(negedge core_clk);
      chkSample(dataOut, c - v[13:0]);
      host.xfer(1'b1, 2'h1, `SCDF_ADDR_DCC_VAL_HI, 2, 1'b0, d);
      chkByte(d[0], v[15:8]);
      chkByte(d[1], v[7:0]);
      wr(`SCDF_ADDR_DCC_CTRL, 8'h40);
      wr(`SCDF_ADDR_XFER, 8'h01);
      @(negedge core_clk);
      chkSample(dataOut, c);
      $display("test dc correction done");
      test_done;
   end
endmodule
